/* core/cps_pwm.sv */
// compare channel in double-buffered edge pwm mode with avalon-mm registers
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "cps_defines.svh"
module cps_pwm #(
  parameter int W = 16
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire logic [`CPS_ADDR_W-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  input  wire logic [8:0]             oc_ev_i,
  input  wire logic [8:0]             ic_ev_i,
  input  wire logic [4:0]             tmr_ev_i,
  input  wire logic [2:0]             cmp_ev_i,
  input  wire logic                   adc_ev_i,
  input  wire logic                   ctu_ev_i,
  output logic                        compare_output_pin_o,
  output logic                        period_ev_o
);
  // ****************************************
  // registers
  // ****************************************
  cps_pkg::cps_word_t ctrl2_q;
  logic [W-1:0]       duty_primary_q;
  logic [W-1:0]       duty_secondary_q;
  logic [W-1:0]       timer_period_q;
  cps_pkg::cps_word_t presc_q;
  logic [W-1:0]       lat_prim_q;
  logic [W-1:0]       lat_sec_q;
  logic               out_q;
  logic               period_ev_q;
  logic [31:0]        rdata_q;
  cps_pkg::cps_bus_st_t bst_q;
  cps_pkg::cps_bus_st_t bst_d;
  logic [W-1:0]       count;
  logic               wrap;
  cps_src_if          src ();

  // ****************************************
  // bus decode
  // ****************************************
  // one wait state on every access so read data come from a flop
  wire req      = avs_read_i || avs_write_i;
  wire take     = ce_i && (bst_q == cps_pkg::CPS_BUS_ACK);
  wire wr_take  = take && avs_write_i;
  wire lo_en    = avs_byteenable_i[0];
  wire hi_en    = avs_byteenable_i[1];
  wire sel_ctrl = (avs_address_i == `CPS_OFF_CTRL2);
  wire sel_dp   = (avs_address_i == `CPS_OFF_DUTYP);
  wire sel_ds   = (avs_address_i == `CPS_OFF_DUTYS);
  wire sel_per  = (avs_address_i == `CPS_OFF_PERIOD);
  wire sel_pre  = (avs_address_i == `CPS_OFF_PRESC);
  wire sel_st   = (avs_address_i == `CPS_OFF_STATUS);
  wire [15:0] wmask = {{8{hi_en}}, {8{lo_en}}};
  wire [15:0] wdat  = avs_writedata_i[15:0];
  wire enable  = ctrl2_q[`CPS_EN_BIT];
  wire [31:0] rd_mux = sel_ctrl ? {16'h0000, ctrl2_q}
                     : sel_dp   ? 32'(duty_primary_q)
                     : sel_ds   ? 32'(duty_secondary_q)
                     : sel_per  ? 32'(timer_period_q)
                     : sel_pre  ? {16'h0000, presc_q}
                     : sel_st   ? {13'h0000, src.src_trig_only, src.src_valid, out_q,
                                   16'(count)}
                     : `CPS_RST_32;                      // unmapped reads zero

  // bus state: idle, answer, one hold cycle, then back to idle
  always_comb begin
    bst_d = bst_q;
    unique case (bst_q)
      cps_pkg::CPS_BUS_IDLE: if (req) bst_d = cps_pkg::CPS_BUS_ACK;
      cps_pkg::CPS_BUS_ACK:  bst_d = cps_pkg::CPS_BUS_HOLD;
      cps_pkg::CPS_BUS_HOLD: bst_d = cps_pkg::CPS_BUS_IDLE;
      default:               bst_d = cps_pkg::CPS_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) bst_q <= cps_pkg::CPS_BUS_IDLE;
    else if (ce_i) bst_q <= bst_d;
  end

  // waitrequest low only in the ack cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      rdata_q           <= `CPS_RST_32;
    end else if (ce_i) begin
      avs_waitrequest_o <= !(bst_d == cps_pkg::CPS_BUS_ACK);
      rdata_q           <= rd_mux;
    end
  end
  assign avs_readdata_o = rdata_q;

  // software writes at any time, byte lanes honoured
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl2_q          <= `CPS_RST_16;
      duty_primary_q   <= '0;
      duty_secondary_q <= '0;
      timer_period_q   <= '0;
      presc_q          <= `CPS_PRESC_RST;
    end else if (wr_take) begin
      if (sel_ctrl) ctrl2_q <= (ctrl2_q & ~wmask) | (wdat & wmask);
      if (sel_dp)   duty_primary_q   <= W'((duty_primary_q & ~wmask) | (wdat & wmask));
      if (sel_ds)   duty_secondary_q <= W'((duty_secondary_q & ~wmask) | (wdat & wmask));
      if (sel_per)  timer_period_q   <= W'((timer_period_q & ~wmask) | (wdat & wmask));
      if (sel_pre)  presc_q <= (presc_q & ~wmask) | (wdat & wmask);
    end
  end

  // ****************************************
  // source selection and time base
  // ****************************************
  assign src.sel     = ctrl2_q[`CPS_SEL_MSB:`CPS_SEL_LSB];
  assign src.oc_ev   = oc_ev_i;
  assign src.ic_ev   = ic_ev_i;
  assign src.tmr_ev  = tmr_ev_i;
  assign src.cmp_ev  = cmp_ev_i;
  assign src.adc_ev  = adc_ev_i;
  assign src.ctu_ev  = ctu_ev_i;
  assign src.self_ev = period_ev_q;

  cps_src_sel u_sel (
    .s (src)
  );

  // trigger-only and reserved codes never restart the time base
  wire sync = src.src_valid && !src.src_trig_only && src.src_ev;

  cps_timebase #(.W(W)) u_tb (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .run_i    (enable),
    .sync_i   (sync),
    .period_i (timer_period_q),
    .presc_i  (presc_q),
    .count_o  (count),
    .wrap_o   (wrap)
  );

  // ****************************************
  // pwm output
  // ****************************************
  // duty latched at period match or while disabled so the output never glitches
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lat_prim_q <= '0;
      lat_sec_q  <= '0;
    end else if (ce_i && (wrap || !enable)) begin
      lat_prim_q <= duty_primary_q;
      lat_sec_q  <= duty_secondary_q;
    end
  end

  // all-zero holds low, secondary above period holds high
  wire all_zero = (lat_prim_q == '0) && (lat_sec_q == '0) && (timer_period_q == '0);
  wire full     = (lat_sec_q > timer_period_q);
  wire nxt_cnt0 = wrap;
  wire fall     = (count == lat_sec_q) && !wrap;
  // rise on period restart, fall on secondary match
  wire out_d    = !enable ? 1'b0
                : all_zero ? 1'b0
                : full ? 1'b1
                : nxt_cnt0 ? (duty_secondary_q != '0)
                : fall ? 1'b0 : out_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_q       <= 1'b0;
      period_ev_q <= 1'b0;
    end else if (ce_i) begin
      out_q       <= out_d;
      period_ev_q <= wrap;
    end
  end
  assign compare_output_pin_o = out_q;
  assign period_ev_o          = period_ev_q;

  // ****************************************
  // checks
  // ****************************************
  property p_zero_low;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && enable && all_zero) |=> !out_q;
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero duty not low");

  property p_full_high;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && enable && !all_zero && full) |=> out_q;
  endproperty
  a_full_high: assert property (p_full_high) else $error("full duty not high");

  property p_latch_hold;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && enable && !wrap) |=> $stable(lat_sec_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("duty latched mid cycle");

  property p_latch_take;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && wrap) |=> (lat_sec_q == $past(duty_secondary_q));
  endproperty
  a_latch_take: assert property (p_latch_take) else $error("duty not latched at period");

  property p_wrap_count;
    @(posedge clk_i) disable iff (rst_i)
      wrap |-> (count == timer_period_q);
  endproperty
  a_wrap_count: assert property (p_wrap_count) else $error("wrap off period");

  property p_fall;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && enable && !all_zero && !full && fall) |=> !out_q;
  endproperty
  a_fall: assert property (p_fall) else $error("no fall at secondary match");

  property p_rsv_none;
    @(posedge clk_i) disable iff (rst_i)
      (src.sel == `CPS_SEL_RSV0 || src.sel == `CPS_SEL_RSV1) |-> !src.src_valid;
  endproperty
  a_rsv_none: assert property (p_rsv_none) else $error("reserved code selects");

  property p_free;
    @(posedge clk_i) disable iff (rst_i)
      (src.sel == `CPS_SEL_FREE) |-> !sync;
  endproperty
  a_free: assert property (p_free) else $error("free run synced");

  property p_bus_ack;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && req && bst_q == cps_pkg::CPS_BUS_IDLE) |=> !avs_waitrequest_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus answer late");

  property p_bus_once;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !avs_waitrequest_o) |=> avs_waitrequest_o;
  endproperty
  a_bus_once: assert property (p_bus_once) else $error("bus answer held");

  property p_dsec_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr_take && sel_ds && lo_en && hi_en) |=> (16'(duty_secondary_q) == $past(wdat));
  endproperty
  a_dsec_write: assert property (p_dsec_write) else $error("duty write lost");

  property p_rise;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && enable && !all_zero && !full && wrap && (duty_secondary_q != '0)) |=> out_q;
  endproperty
  a_rise: assert property (p_rise) else $error("no rise at period restart");

  property p_period_ev;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && wrap) |=> period_ev_q;
  endproperty
  a_period_ev: assert property (p_period_ev) else $error("period event missing");

  property p_sync_zero;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && enable && sync) |=> (count == '0);
  endproperty
  a_sync_zero: assert property (p_sync_zero) else $error("sync did not restart");

  property p_self_ev;
    @(posedge clk_i) disable iff (rst_i)
      (src.sel == `CPS_SEL_SELF) |-> (src.src_ev == period_ev_q);
  endproperty
  a_self_ev: assert property (p_self_ev) else $error("self source misrouted");

  property p_trig_only;
    @(posedge clk_i) disable iff (rst_i)
      (src.sel == `CPS_SEL_ADC || src.sel == `CPS_SEL_CTU) |-> src.src_trig_only;
  endproperty
  a_trig_only: assert property (p_trig_only) else $error("trigger source syncs");

  property p_rsv_quiet;
    @(posedge clk_i) disable iff (rst_i)
      (src.sel == `CPS_SEL_RSV0 || src.sel == `CPS_SEL_RSV1) |-> !src.src_ev;
  endproperty
  a_rsv_quiet: assert property (p_rsv_quiet) else $error("reserved code fires");
endmodule // cps_pwm

/* core/cps_src_sel.sv */
// trigger and synchronisation source selector
`timescale 1ns/1ps
`include "cps_defines.svh"
module cps_src_sel (
  cps_src_if.sel_m s
);
  // capture channels share scattered codes; map each to its channel index
  wire        is_oc   = (s.sel >= `CPS_SEL_OUTC1) && (s.sel <= `CPS_SEL_OUTC9);
  wire        is_tmr  = (s.sel >= `CPS_SEL_TIM1) && (s.sel <= `CPS_SEL_TIM5);
  wire        is_icl  = (s.sel >= `CPS_SEL_IC7) && (s.sel <= `CPS_SEL_IC4);
  wire        is_cmp  = (s.sel >= `CPS_SEL_CMP1) && (s.sel <= `CPS_SEL_CMP3);
  wire        is_rsv  = (s.sel == `CPS_SEL_RSV0) || (s.sel == `CPS_SEL_RSV1);
  wire [4:0]  oc_i    = s.sel - `CPS_SEL_OUTC1;
  wire [4:0]  tmr_i   = s.sel - `CPS_SEL_TIM1;
  wire [4:0]  icl_i   = s.sel - `CPS_SEL_IC7;
  wire [4:0]  cmp_i   = s.sel - `CPS_SEL_CMP1;
  // low capture range order 7,8,1,2,3,4
  wire [3:0]  ic_ch   = (icl_i == 5'h00) ? 4'h6 : (icl_i == 5'h01) ? 4'h7
                        : 4'(icl_i - 5'h02);
  wire        ic_hit  = is_icl ? s.ic_ev[ic_ch]
                      : (s.sel == `CPS_SEL_IC5) ? s.ic_ev[4]
                      : (s.sel == `CPS_SEL_IC6) ? s.ic_ev[5]
                      : (s.sel == `CPS_SEL_IC9) ? s.ic_ev[8] : 1'b0;
  wire        is_ic   = is_icl || (s.sel == `CPS_SEL_IC5) || (s.sel == `CPS_SEL_IC6)
                        || (s.sel == `CPS_SEL_IC9);
  // event routing; reserved and free-running codes never fire
  assign s.src_ev = is_oc ? s.oc_ev[oc_i[3:0]]
                  : is_tmr ? s.tmr_ev[tmr_i[2:0]]
                  : is_ic ? ic_hit
                  : is_cmp ? s.cmp_ev[cmp_i[1:0]]
                  : (s.sel == `CPS_SEL_ADC) ? s.adc_ev
                  : (s.sel == `CPS_SEL_CTU) ? s.ctu_ev
                  : (s.sel == `CPS_SEL_SELF) ? s.self_ev : 1'b0;
  assign s.src_valid = (s.sel != `CPS_SEL_FREE) && !is_rsv;
  // trigger-only sources are flagged so the timebase never syncs to them
  assign s.src_trig_only = is_ic || is_cmp || (s.sel == `CPS_SEL_ADC)
                         || (s.sel == `CPS_SEL_CTU);
endmodule // cps_src_sel

/* core/cps_timebase.sv */
// prescaled timer time base with period compare
`timescale 1ns/1ps
`include "cps_defines.svh"
module cps_timebase #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         run_i,
  input  wire logic         sync_i,
  input  wire logic [W-1:0] period_i,
  input  wire logic [15:0]  presc_i,
  output logic      [W-1:0] count_o,
  output logic              wrap_o
);
  logic [15:0]  icyc_q;
  logic [15:0]  pre_q;
  logic [W-1:0] cnt_q;
  // one tick per instruction cycle times (prescale + 1)
  wire icyc_end = (icyc_q == 16'(`CPS_ICYC_CLKS - 1));
  wire tick     = icyc_end && (pre_q == presc_i);
  wire at_per   = (cnt_q >= period_i);
  assign wrap_o  = run_i && tick && at_per;
  assign count_o = cnt_q;
  // period of N gives N+1 counts
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      icyc_q <= `CPS_RST_16;
      pre_q  <= `CPS_RST_16;
      cnt_q  <= '0;
    end else if (ce_i) begin
      if (!run_i || sync_i) begin
        icyc_q <= `CPS_RST_16;
        pre_q  <= `CPS_RST_16;
        cnt_q  <= '0;
      end else begin
        icyc_q <= icyc_end ? `CPS_RST_16 : icyc_q + `CPS_ONE_16;
        if (icyc_end) pre_q <= (pre_q == presc_i) ? `CPS_RST_16 : pre_q + `CPS_ONE_16;
        if (tick) cnt_q <= at_per ? '0 : cnt_q + W'(1);
      end
    end
  end
endmodule // cps_timebase

/* inc/cps_defines.svh */
// register offsets, field positions, reset values and timing constants for the compare channel
`ifndef CPS_DEFINES_SVH
`define CPS_DEFINES_SVH

// ****************************************
// register map (word addresses)
// ****************************************
`define CPS_OFF_CTRL2   4'h0
`define CPS_OFF_DUTYP   4'h1
`define CPS_OFF_DUTYS   4'h2
`define CPS_OFF_PERIOD  4'h3
`define CPS_OFF_PRESC   4'h4
`define CPS_OFF_STATUS  4'h5
`define CPS_ADDR_W      4

// ****************************************
// fields and reset values
// ****************************************
`define CPS_SEL_LSB     0
`define CPS_SEL_MSB     4
`define CPS_EN_BIT      15
`define CPS_RST_16      16'h0000
`define CPS_RST_32      32'h0000_0000
`define CPS_ONE_16      16'h0001
`define CPS_PRESC_RST   16'h0000

// ****************************************
// source selector codes
// ****************************************
`define CPS_SEL_FREE    5'h00
`define CPS_SEL_OUTC1   5'h01
`define CPS_SEL_OUTC9   5'h09
`define CPS_SEL_IC5     5'h0A
`define CPS_SEL_TIM1    5'h0B
`define CPS_SEL_TIM5    5'h0F
`define CPS_SEL_RSV0    5'h10
`define CPS_SEL_RSV1    5'h11
`define CPS_SEL_IC7     5'h12
`define CPS_SEL_IC4     5'h17
`define CPS_SEL_CMP1    5'h18
`define CPS_SEL_CMP3    5'h1A
`define CPS_SEL_ADC     5'h1B
`define CPS_SEL_CTU     5'h1C
`define CPS_SEL_IC6     5'h1D
`define CPS_SEL_IC9     5'h1E
`define CPS_SEL_SELF    5'h1F

// ****************************************
// timing: instruction cycle is two oscillator periods
// ****************************************
`define CPS_OSC_PER_NS  5
`define CPS_CLK_PER_NS  10
`define CPS_ICYC_NS     (2 * `CPS_OSC_PER_NS)
`define CPS_ICYC_CLKS   ((`CPS_ICYC_NS + `CPS_CLK_PER_NS - 1) / `CPS_CLK_PER_NS)

`endif

/* inc/cps_pkg.sv */
// types shared by the compare channel modules
package cps_pkg;
  typedef enum logic [2:0] {
    CPS_BUS_IDLE = 3'b001,
    CPS_BUS_ACK  = 3'b010,
    CPS_BUS_HOLD = 3'b100
  } cps_bus_st_t;
  typedef logic [15:0] cps_word_t;
endpackage

/* inc/cps_src_if.sv */
// source selection carrier between the top and the selector
`timescale 1ns/1ps
interface cps_src_if;
  logic [4:0]  sel;
  logic [8:0]  oc_ev;
  logic [8:0]  ic_ev;
  logic [4:0]  tmr_ev;
  logic [2:0]  cmp_ev;
  logic        adc_ev;
  logic        ctu_ev;
  logic        self_ev;
  logic        src_ev;
  logic        src_valid;
  logic        src_trig_only;
  modport top (output sel, oc_ev, ic_ev, tmr_ev, cmp_ev, adc_ev, ctu_ev, self_ev,
               input src_ev, src_valid, src_trig_only);
  modport sel_m (input sel, oc_ev, ic_ev, tmr_ev, cmp_ev, adc_ev, ctu_ev, self_ev,
                 output src_ev, src_valid, src_trig_only);
endinterface

/* tb/compare_pwm_sync_select_tb.sv */
// self-checking bench for the double-buffered pwm compare channel
`timescale 1ns/1ps
module compare_pwm_sync_select_tb;
  logic        clk_i;
  logic        rst_i;
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wait_r;
  logic [8:0]  oc_ev;
  logic [8:0]  ic_ev;
  logic [4:0]  tmr_ev;
  logic        pin;
  logic        pev;
  logic [15:0] high_w;
  logic [15:0] per_w;
  logic [15:0] rises;
  logic [31:0] q;
  int          err_count;
  int          check_count;
  int          cycles;
  cps_pwm u_cps_pwm (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r), .oc_ev_i(oc_ev), .ic_ev_i(ic_ev),
    .tmr_ev_i(tmr_ev), .cmp_ev_i(3'h0), .adc_ev_i(1'b0), .ctu_ev_i(1'b0),
    .compare_output_pin_o(pin), .period_ev_o(pev));
  cps_load_model u_cps_load_model (.clk_i(clk_i), .pin_i(pin), .high_o(high_w),
    .per_o(per_w), .rises_o(rises));
  // ****
  // clock, timeout and closing report
  // ****
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("TB: checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // registered compare may land one tick late, so widths get a window
  task automatic check_in(input logic [31:0] got, input logic [31:0] lo,
                          input logic [31:0] hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // ****
  // bus and stimulus helpers
  // ****
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d,
                     input logic [3:0] b);
    @(posedge clk_i);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= {16'h0000, d};
    be    <= b;
    @(posedge clk_i);
    while (wait_r !== 1'b0) @(posedge clk_i);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 4'h3);
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic wait_rise();
    logic [15:0] r;
    int          n;
    r = rises;
    n = 0;
    while (rises === r && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    // a missing edge is a failure, not a silent skip
    if (n >= 2000) begin
      err_count++;
      $display("BAD t=%0t no rise got=%h exp=%h", $time, rises, r + 16'h0001);
    end
  endtask
  task automatic pulse(input logic [4:0] t, input logic [8:0] o, input logic [8:0] i);
    @(posedge clk_i);
    tmr_ev <= t;
    oc_ev  <= o;
    ic_ev  <= i;
    @(posedge clk_i);
    tmr_ev <= 5'h00;
    oc_ev  <= 9'h000;
    ic_ev  <= 9'h000;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs();
    for (int a = 0; a < 5; a++) begin
      bus(1'b0, 4'(a), 16'h0000, 4'h3);
      check_eq(q, 32'h0000_0000);
    end
    wreg(4'h1, 16'hABCD);
    bus(1'b0, 4'h1, 16'h0000, 4'h3);
    check_eq(q, 32'h0000_ABCD);
    wreg(4'h2, 16'hFFFF);
    bus(1'b1, 4'h2, 16'h1234, 4'h1);
    bus(1'b0, 4'h2, 16'h0000, 4'h3);
    check_eq(q, 32'h0000_FF34);
    wreg(4'h6, 16'h5A5A);
    bus(1'b0, 4'h6, 16'h0000, 4'h3);
    check_eq(q, 32'h0000_0000);
    $display("TB: registers done");
  endtask
  task automatic t_period();
    int n[3] = '{3, 7, 9};
    int p[3] = '{1, 0, 2};
    int d[3] = '{1, 3, 5};
    int hits;
    for (int k = 0; k < 3; k++) begin
      do_reset();
      wreg(4'h3, 16'(n[k]));
      wreg(4'h4, 16'(p[k]));
      wreg(4'h2, 16'(d[k]));
      wreg(4'h0, 16'h8000);
      repeat (3) wait_rise();
      check_eq(32'(per_w), 32'((n[k] + 1) * (p[k] + 1)));
      check_in(32'(high_w), 32'(d[k] * (p[k] + 1)), 32'((d[k] + 1) * (p[k] + 1)));
      // exactly one period event in any window one period long
      hits = 0;
      repeat ((n[k] + 1) * (p[k] + 1)) begin
        @(posedge clk_i);
        hits += (pev === 1'b1);
      end
      check_eq(32'(hits), 32'h0000_0001);
    end
    $display("TB: period and duty done");
  endtask
  task automatic t_dbuf();
    do_reset();
    wreg(4'h3, 16'h000F);
    wreg(4'h2, 16'h000C);
    wreg(4'h0, 16'h8000);
    wait_rise();
    wait_rise();
    // new width lands before count reaches it, so an early take would show
    wreg(4'h2, 16'h000A);
    wreg(4'h1, 16'h0001);
    wait_rise();
    check_in(32'(high_w), 32'h0000_000C, 32'h0000_000D);
    wait_rise();
    check_in(32'(high_w), 32'h0000_000A, 32'h0000_000B);
    $display("TB: double buffer done");
  endtask
  task automatic t_bounds();
    int hits;
    do_reset();
    wreg(4'h0, 16'h8000);
    hits = 0;
    repeat (64) begin
      @(posedge clk_i);
      hits += (pin !== 1'b0);
    end
    check_eq(32'(hits), 32'h0000_0000);
    do_reset();
    wreg(4'h3, 16'h0005);
    wreg(4'h2, 16'h0006);
    wreg(4'h0, 16'h8000);
    repeat (20) @(posedge clk_i);
    hits = 0;
    repeat (48) begin
      @(posedge clk_i);
      hits += (pin !== 1'b1);
    end
    check_eq(32'(hits), 32'h0000_0000);
    $display("TB: boundaries done");
  endtask
  task automatic t_sel();
    logic v;
    logic t;
    do_reset();
    for (int c = 0; c < 32; c++) begin
      v = !(c == 0 || c == 16 || c == 17);
      t = (c == 10) || (c >= 18 && c <= 30);
      wreg(4'h0, 16'(c));
      bus(1'b0, 4'h5, 16'h0000, 4'h3);
      check_eq(32'(q[18:17]), 32'({t, v}));
    end
    $display("TB: selector codes done");
  endtask
  task automatic t_sync();
    logic [15:0] code[3] = '{16'h800C, 16'h8003, 16'h8014};
    for (int k = 0; k < 3; k++) begin
      do_reset();
      wreg(4'h3, 16'h00C8);
      wreg(4'h0, code[k]);
      repeat (60) @(posedge clk_i);
      pulse(5'h02 & {5{k == 0}}, 9'h004 & {9{k == 1}}, 9'h001 & {9{k == 2}});
      bus(1'b0, 4'h5, 16'h0000, 4'h3);
      if (k < 2) begin
        check_in(32'(q[15:0]), 32'h0000_0000, 32'h0000_0008);
      end else begin
        check_in(32'(q[15:0]), 32'h0000_0037, 32'h0000_0060);
      end
    end
    $display("TB: synchronisation done");
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    clk_i       = 1'b0;
    rst_i       = 1'b1;
    addr        = 4'h0;
    rd          = 1'b0;
    wr          = 1'b0;
    wdata       = 32'h0000_0000;
    be          = 4'h0;
    oc_ev       = 9'h000;
    ic_ev       = 9'h000;
    tmr_ev      = 5'h00;
    err_count   = 0;
    check_count = 0;
    cycles      = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_period();
    t_dbuf();
    t_bounds();
    t_sel();
    t_sync();
    stop_test();
  end
endmodule // compare_pwm_sync_select_tb

/* tb/cps_load_model.sv */
// load on the compare output: measures high time and cycle length in clocks
`timescale 1ns/1ps
module cps_load_model (
  input  wire logic        clk_i,
  input  wire logic        pin_i,
  output logic      [15:0] high_o,
  output logic      [15:0] per_o,
  output logic      [15:0] rises_o
);
  logic        pin_q;
  logic [15:0] hcnt_q;
  logic [15:0] pcnt_q;
  initial begin
    pin_q   = 1'b0;
    hcnt_q  = 16'h0000;
    pcnt_q  = 16'h0000;
    high_o  = 16'h0000;
    per_o   = 16'h0000;
    rises_o = 16'h0000;
  end
  // a purely resistive load: it only samples, it never drives back
  always @(posedge clk_i) begin
    pin_q  <= pin_i;
    pcnt_q <= pcnt_q + 16'h0001;
    if (pin_i) begin
      hcnt_q <= hcnt_q + 16'h0001;
    end
    if (pin_i && !pin_q) begin
      per_o   <= pcnt_q;
      pcnt_q  <= 16'h0001;
      hcnt_q  <= 16'h0001;
      rises_o <= rises_o + 16'h0001;
    end
    if (!pin_i && pin_q) begin
      high_o <= hcnt_q;
    end
  end
endmodule // cps_load_model
